// file: include/fbs_pkg.sv
// Purpose: shared constants and types of the flash bitstream server
// Assumes: one fast clock; serial link pins are sampled, never used as clocks
// Notes: the serial clock arrives from the configured part and may stop
package fbs_pkg;
    localparam int BYTE_W = 8;                 // width of one stored byte
    localparam int ADDR_W = 24;                // serial start address width
    localparam int BANK_AW = 18;               // index width inside one bank
    localparam int BANK_WORDS = 262144;        // bytes held by each bank
    localparam int BANK_SEL_BIT = 18;          // address bit picking the bank
    localparam logic [7:0] READ_CODE = 8'h03;  // only command served
    localparam logic [2:0] LAST_BIT = 3'h7;    // bit counter value of eighth bit
    localparam int PIN_SCLK = 0;               // serial clock pin index
    localparam int PIN_CS_N = 1;               // chip select pin index
    localparam int PIN_MOSI = 2;               // command/address data pin index
    localparam int PIN_MODE = 3;               // mode strap pin index
    localparam int PIN_N = 4;                  // number of sampled pins

    // serial state machine
    typedef enum logic [2:0] {
        FBS_CMD = 3'b000,
        FBS_ADDR0 = 3'b001,
        FBS_ADDR1 = 3'b010,
        FBS_ADDR2 = 3'b011,
        FBS_READ = 3'b100,
        FBS_IGNORE = 3'b101,
        FBS_MSER = 3'b110
    } fbs_state_t;

    // preload port for the nonvolatile banks
    typedef struct packed {
        logic en;                              // write strobe
        logic [BANK_AW:0] addr;                // bit 18 selects the high bank
        logic [BYTE_W-1:0] data;               // byte to store
    } fbs_flash_wr_t;

    // complete state of the server
    typedef struct packed {
        logic [PIN_N-1:0] sync1;               // first sampling stage
        logic [PIN_N-1:0] sync2;               // second sampling stage
        logic [PIN_N-1:0] sync3;               // third sampling stage
        logic [PIN_N-1:0] lvl;                 // accepted pin levels
        fbs_state_t state;                     // serial state
        logic [2:0] in_cnt;                    // bits taken in current byte
        logic [BYTE_W-1:0] in_sh;              // incoming shift register
        logic [ADDR_W-1:0] addr;               // memory read address
        logic [2:0] out_cnt;                   // bits sent of current byte
        logic [BYTE_W-1:0] out_sh;             // outgoing shift register
        logic bit_out;                         // serial data pin
        logic oe;                              // serial data pin enable
        logic load;                            // byte load pulse
    } fbs_regs_t;

    localparam fbs_regs_t REGS_RST = '{
        sync1: 4'h2, sync2: 4'h2, sync3: 4'h2, lvl: 4'h2,
        state: FBS_CMD, in_cnt: 3'h0, in_sh: 8'h00, addr: 24'h000000,
        out_cnt: 3'h0, out_sh: 8'h00, bit_out: 1'b0, oe: 1'b0, load: 1'b0
    };
endpackage

// file: tb/fbs_host_model.sv
// Purpose: behavioural model of the configured part that clocks the server
// Assumes: all timing from the caller's start point, which sits just after a clk edge
// Notes: sclk stands low between frames; released mosi flips to its inverse
`timescale 1ns/1ps
module fbs_host_model
(
    input wire logic bit_in,    // data pin from the server
    output logic sclk_out,      // serial clock made by the host
    output logic cs_n_out,      // chip select, active low
    output logic mosi_out       // command and address bits
);
    localparam realtime HALF = 80.0;   // half of the 160 ns serial period
    logic [7:0] rx_bytes[$];           // bytes taken in the last frame

    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // one frame: header bits set before each rise, data bits sampled before each rise
    task automatic frame(input logic [31:0] hdr, input int nhdr, input int nbits);
        logic [7:0] acc;
        acc = 8'h00;
        rx_bytes.delete();
        cs_n_out = 1'b0;
        #(2 * HALF);
        for (int i = 0; i < nhdr; i++)
        begin
            mosi_out = hdr[31 - i];
            #HALF;
            sclk_out = 1'b1;
            #HALF;
            sclk_out = 1'b0;
        end
        // released line must not keep its last level
        mosi_out = ~mosi_out;
        // host clocks; without a header one rise precedes the first fall
        if (nhdr == 0)
        begin
            sclk_out = 1'b1;
            #HALF;
            sclk_out = 1'b0;
        end
        for (int i = 0; i < nbits; i++)
        begin
            #HALF;
            acc = {acc[6:0], bit_in};
            if (i % 8 == 7)
                rx_bytes.push_back(acc);
            sclk_out = 1'b1;
            #HALF;
            sclk_out = 1'b0;
        end
        #HALF;
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
    endtask
endmodule

// file: tb/tb_flash_bitstream_server.sv
// Purpose: self-checking bench for the bitstream server in both link modes
// Assumes: banks preloaded before any frame; host model drives the link
// Notes: each scenario is one task that judges its own result
`timescale 1ns/1ps
module tb_flash_bitstream_server;
    import fbs_pkg::*;
    logic clk_in = 1'b0;               // fast clock
    logic rst_n_in = 1'b0;             // reset, active low
    logic mode_mser_in = 1'b0;         // link mode strap
    fbs_flash_wr_t flash_wr_in = '0;   // preload port
    logic sclk, cs_n, mosi;            // link from host model
    logic config_bit_out_out, config_bit_oe_out, byte_load_out;
    int err_total = 0;
    int num_checks = 0;
    int loads = 0;                     // load pulses seen
    logic oe_seen = 1'b0;              // data pin was driven

    always #2 clk_in = ~clk_in;

    // watch the pulse and the pin enable
    always @(posedge clk_in)
    begin
        if (byte_load_out === 1'b1)
            loads++;
        if (config_bit_oe_out === 1'b1)
            oe_seen = 1'b1;
    end

    fbs_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .config_serial_clock_in(sclk),
        .cs_n_in(cs_n), .mosi_in(mosi), .mode_mser_in(mode_mser_in),
        .flash_wr_in(flash_wr_in), .config_bit_out_out(config_bit_out_out),
        .config_bit_oe_out(config_bit_oe_out), .byte_load_out(byte_load_out));
    fbs_host_model host (.bit_in(config_bit_out_out), .sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi));

    // stored pattern; bank bit folded in so the banks differ
    function automatic logic [7:0] exp_byte(input logic [18:0] a);
        return a[7:0] ^ 8'h35 ^ {a[18], 7'h00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t ns: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic sync(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // two-byte read from a, load pulse count included
    task automatic spi_read(input logic [18:0] a);
        sync(12);
        loads = 0;
        host.frame({READ_CODE, 5'h00, a}, 32, 16);
        chk(host.rx_bytes.size(), 2);
        chk(host.rx_bytes[0], exp_byte(a));
        chk(host.rx_bytes[1], exp_byte(a + 19'h1));
        chk(loads, 3);
    endtask

    task automatic t_spi_basic();
        spi_read(19'h00000);
    endtask

    task automatic t_bank_cross();
        spi_read(19'h3ffff);
    endtask

    // wrong command: pin never driven, then a fresh frame is served
    task automatic t_bad_cmd();
        sync(12);
        oe_seen = 1'b0;
        host.frame(32'h0b000000, 32, 16);
        chk(host.rx_bytes[0], 8'h00);
        chk(oe_seen, 1'b0);
        spi_read(19'h00002);
    endtask

    // deselect in mid byte releases the pin within a bounded time
    task automatic t_abort();
        int n;
        sync(12);
        oe_seen = 1'b0;
        host.frame({READ_CODE, 24'h000000}, 32, 3);
        chk(oe_seen, 1'b1);
        n = 0;
        while (config_bit_oe_out !== 1'b0 && n < 12)
        begin
            sync(1);
            n++;
        end
        if (n == 12)
        begin
            err_total++;
            end_sim();
        end
        chk(config_bit_out_out, 1'b0);
        spi_read(19'h00001);
    endtask

    // master serial: host clock only, stream from address zero
    task automatic t_mser();
        mode_mser_in = 1'b1;
        sync(12);
        loads = 0;
        host.frame(32'h0, 0, 16);
        chk(host.rx_bytes[0], exp_byte(19'h0));
        chk(host.rx_bytes[1], exp_byte(19'h1));
        chk(loads, 3);
        sync(12);
        mode_mser_in = 1'b0;
    endtask

    initial
    begin
        sync(12);
        chk({config_bit_oe_out, config_bit_out_out, byte_load_out}, 3'h0);
        rst_n_in = 1'b1;
        // low bytes 0..4 and 3ffff..40001: every two-byte read also loads a third byte,
        // so that byte must be stored too or the fetched msb would be unknown
        for (int i = 0; i < 8; i++)
        begin
            sync(1);
            flash_wr_in = '{en: 1'b1, addr: (i < 5) ? 19'(i) : 19'(19'h3fffa + i),
                data: exp_byte((i < 5) ? 19'(i) : 19'(19'h3fffa + i))};
        end
        sync(1);
        flash_wr_in = '0;
        t_spi_basic();
        t_bank_cross();
        t_bad_cmd();
        t_abort();
        t_mser();
        end_sim();
    end

    // hang guard
    initial
    begin
        #300000;
        err_total++;
        end_sim();
    end
endmodule

// file: verilog/fbs_top.sv
// Purpose: serves a stored bitstream as a read-only serial flash or master serial slave
// Assumes: clk_in at 250 MHz, serial clock much slower (160 ns in the bench)
// Notes: banks are preloaded through the write port before the link is used
`timescale 1ns/1ps
module fbs_top
    import fbs_pkg::*;
(
    input wire logic clk_in,                    // fast clock, 250 MHz
    input wire logic rst_n_in,                  // synchronous reset, active low
    input wire logic config_serial_clock_in,    // serial clock from host
    input wire logic cs_n_in,                   // chip select, active low
    input wire logic mosi_in,                   // command and address bits
    input wire logic mode_mser_in,              // high selects master serial
    input wire fbs_flash_wr_t flash_wr_in,      // bank preload port
    output logic config_bit_out_out,            // serial configuration data
    output logic config_bit_oe_out,             // data pin enable, high drives
    output logic byte_load_out                  // one-cycle pulse per loaded byte
);
    fbs_regs_t st_q;                            // registered state
    fbs_regs_t st_d;                            // next state
    logic [BYTE_W-1:0] flash_bank_low [BANK_WORDS];  // first part of stream
    logic [BYTE_W-1:0] flash_bank_high [BANK_WORDS]; // remainder of stream
    logic [BYTE_W-1:0] rd_q;                    // fetched byte
    logic sclk_rise;                            // accepted rising serial edge
    logic sclk_fall;                            // accepted falling serial edge
    logic [BYTE_W-1:0] byte_in;                 // byte completed by current bit

    // picks the high bank for a bank-relative address
    function automatic logic bank_is_high(input logic [BANK_AW:0] a);
        return a[BANK_SEL_BIT];
    endfunction

    // bank storage and split
    // one fetch per fast cycle keeps flash latency far below one serial half period
    always_ff @(posedge clk_in)
    begin
        if (flash_wr_in.en)
        begin
            if (bank_is_high(flash_wr_in.addr))
                flash_bank_high[flash_wr_in.addr[BANK_AW-1:0]] <= flash_wr_in.data;
            else
                flash_bank_low[flash_wr_in.addr[BANK_AW-1:0]] <= flash_wr_in.data;
        end
        if (bank_is_high(st_q.addr[BANK_AW:0]))
            rd_q <= flash_bank_high[st_q.addr[BANK_AW-1:0]];
        else
            rd_q <= flash_bank_low[st_q.addr[BANK_AW-1:0]];
    end

    // next-state logic: pin filtering, serial decode and shifting
    always_comb
    begin
        st_d = st_q;
        st_d.load = 1'b0;
        // three-stage sampling; a level counts once stages two and three agree
        st_d.sync1 = {mode_mser_in, mosi_in, cs_n_in, config_serial_clock_in};
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        for (int i = 0; i < PIN_N; i++)
        begin
            if (st_q.sync2[i] == st_q.sync3[i])
                st_d.lvl[i] = st_q.sync3[i];
        end
        sclk_rise = !st_q.lvl[PIN_SCLK] && st_d.lvl[PIN_SCLK];
        sclk_fall = st_q.lvl[PIN_SCLK] && !st_d.lvl[PIN_SCLK];
        byte_in = {st_q.in_sh[BYTE_W-2:0], st_q.lvl[PIN_MOSI]};

        if (st_q.lvl[PIN_CS_N])
        begin
            st_d.state = FBS_CMD;
            st_d.in_cnt = 3'h0;
            st_d.out_cnt = 3'h0;
            st_d.addr = '0;
            st_d.bit_out = 1'b0;
            st_d.oe = 1'b0;
        end
        else
        begin
            unique case (st_q.state)
                FBS_CMD,
                FBS_ADDR0,
                FBS_ADDR1,
                FBS_ADDR2:
                begin
                    if (st_q.state == FBS_CMD && st_q.lvl[PIN_MODE])
                    begin
                        // host clock drives master serial streaming
                        st_d.state = FBS_MSER;
                        st_d.oe = 1'b1;
                    end
                    // data is taken on the rising serial edge, the level settled before it
                    else if (sclk_rise)
                    begin
                        st_d.in_sh = byte_in;
                        st_d.in_cnt = st_q.in_cnt + 3'h1;
                        if (st_q.in_cnt == LAST_BIT)
                        begin
                            unique case (st_q.state)
                                FBS_CMD:
                                begin
                                    st_d.state = (byte_in == READ_CODE) ? FBS_ADDR0 : FBS_IGNORE;
                                end
                                FBS_ADDR0:
                                begin
                                    st_d.addr = {st_q.addr[ADDR_W-9:0], byte_in};
                                    st_d.state = FBS_ADDR1;
                                end
                                FBS_ADDR1:
                                begin
                                    st_d.addr = {st_q.addr[ADDR_W-9:0], byte_in};
                                    st_d.state = FBS_ADDR2;
                                end
                                default:
                                begin
                                    st_d.addr = {st_q.addr[ADDR_W-9:0], byte_in};
                                    st_d.state = FBS_READ;
                                    st_d.out_cnt = 3'h0;
                                end
                            endcase
                        end
                    end
                end
                FBS_READ,
                FBS_MSER:
                begin
                    if (sclk_fall)
                    begin
                        st_d.oe = 1'b1;
                        st_d.out_cnt = st_q.out_cnt + 3'h1;
                        if (st_q.out_cnt == 3'h0)
                        begin
                            // first bit of each byte; in read, the first of them right after the address, in master serial on the first fall
                            // load a byte every eight bits
                            st_d.bit_out = rd_q[BYTE_W-1];
                            st_d.out_sh = {rd_q[BYTE_W-2:0], 1'b0};
                            st_d.addr = st_q.addr + 24'h000001;
                            st_d.load = 1'b1;
                        end
                        else
                        begin
                            st_d.bit_out = st_q.out_sh[BYTE_W-1];
                            st_d.out_sh = {st_q.out_sh[BYTE_W-2:0], 1'b0};
                        end
                    end
                end
                FBS_IGNORE:
                begin
                    st_d.bit_out = 1'b0;
                    st_d.oe = 1'b0;
                end
                default:
                begin
                    // illegal code: recover through command capture
                    st_d.state = FBS_CMD;
                end
            endcase
        end
    end

    // state register, synchronous reset
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            st_q <= REGS_RST;
        else
            st_q <= st_d;
    end

    // outputs straight from flip-flops
    assign config_bit_out_out = st_q.bit_out;
    assign config_bit_oe_out = st_q.oe;
    assign byte_load_out = st_q.load;

    // checks on the serial behaviour
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_cmd_read_ok: assert property (
        (!st_q.lvl[PIN_CS_N] && st_q.state == FBS_CMD && !st_q.lvl[PIN_MODE] && sclk_rise
            && st_q.in_cnt == LAST_BIT && byte_in == READ_CODE) |=> st_q.state == FBS_ADDR0)
        else $error("read code did not start address capture");
    a_cmd_bad_idle: assert property (
        (!st_q.lvl[PIN_CS_N] && st_q.state == FBS_CMD && !st_q.lvl[PIN_MODE] && sclk_rise
            && st_q.in_cnt == LAST_BIT && byte_in != READ_CODE)
            |=> st_q.state == FBS_IGNORE ##1 !st_q.oe)
        else $error("bad command not ignored");
    a_addr_to_read: assert property (
        (!st_q.lvl[PIN_CS_N] && st_q.state == FBS_ADDR2 && sclk_rise && st_q.in_cnt == LAST_BIT)
            |=> st_q.state == FBS_READ && st_q.addr[7:0] == $past(byte_in))
        else $error("address capture did not end in read state");
    a_deselect_idle: assert property (
        st_q.lvl[PIN_CS_N] |=> st_q.state == FBS_CMD && !st_q.oe && st_q.in_cnt == 3'h0)
        else $error("deselect did not return to command capture");
    a_first_bit_msb: assert property (
        (!st_q.lvl[PIN_CS_N] && st_q.state == FBS_READ && sclk_fall && st_q.out_cnt == 3'h0)
            |=> st_q.bit_out == $past(rd_q[BYTE_W-1]) && st_q.oe && st_q.load)
        else $error("first bit of byte not driven from fetched msb");
    a_shift_next_bit: assert property (
        (!st_q.lvl[PIN_CS_N] && st_q.state == FBS_READ && sclk_fall && st_q.out_cnt != 3'h0)
            |=> st_q.bit_out == $past(st_q.out_sh[BYTE_W-1]) && !st_q.load)
        else $error("read state did not shift next bit");
    a_mser_load_addr: assert property (
        (!st_q.lvl[PIN_CS_N] && st_q.state == FBS_MSER && sclk_fall && st_q.out_cnt == 3'h0)
            |=> st_q.load && st_q.addr == $past(st_q.addr) + 24'h000001 ##1 !st_q.load)
        else $error("master serial byte load missing");
    a_mser_shift_msb: assert property (
        (!st_q.lvl[PIN_CS_N] && st_q.state == FBS_MSER && sclk_fall && st_q.out_cnt != 3'h0)
            |=> st_q.bit_out == $past(st_q.out_sh[BYTE_W-1]))
        else $error("master serial bit order wrong");
    a_bit_hold_no_edge: assert property (
        (!st_q.lvl[PIN_CS_N] && st_q.state == FBS_READ && !sclk_fall && !st_d.lvl[PIN_CS_N])
            |=> $stable(st_q.bit_out))
        else $error("data changed without a falling edge");

    c_spi_read: cover property (st_q.state == FBS_READ && st_q.load);
    c_bad_cmd: cover property (st_q.state == FBS_IGNORE);
    c_mser_load: cover property (st_q.state == FBS_MSER && st_q.load);
    c_high_bank: cover property (st_q.load && st_q.addr[BANK_SEL_BIT]);
endmodule
